/* rtl/gdrv_consts.svh */
// Register offsets, field positions, reset values and frame constants of the fault status block
// Summary of operation
// - Phase U ground short sets bit 5, disables.
// - Phase U supply short sets bit 6, disables.
// - Phase V short counter trigger latches bit 8.
// - Phase V ground short sets bit 9, disables.
// - Phase V supply short sets bit 10, disables.
// - Phase W short counter trigger latches bit 12.
// - Phase W ground short sets bit 13, disables.
// - Phase W supply short sets bit 14, disables.
// - Fault output is OR of all flags.
// - Readback bits 0-6: gate inputs, driver enable.
// - Readback bits 31-24 hold silicon version.
// - Fuse register write sends 16 bits, one strobe.
// - Writing one clears flag; zero keeps it.
// - Driver enable off-on clears all flags.
// - Flag clear alone never re-enables transistor.
// - Phase U short counter latches bit 4.
`ifndef GDRV_CONSTS_SVH
`define GDRV_CONSTS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define GDRV_ADDR_FLAGS 7'h01
`define GDRV_ADDR_READBACK 7'h04
`define GDRV_ADDR_FUSE 7'h06

// ---------------------------------------------------------------
// Flag field positions
// ---------------------------------------------------------------
`define GDRV_FLG_CNT_U 4
`define GDRV_FLG_GND_U 5
`define GDRV_FLG_SUP_U 6
`define GDRV_FLG_CNT_V 8
`define GDRV_FLG_GND_V 9
`define GDRV_FLG_SUP_V 10
`define GDRV_FLG_CNT_W 12
`define GDRV_FLG_GND_W 13
`define GDRV_FLG_SUP_W 14

// ---------------------------------------------------------------
// Masks and reset values
// ---------------------------------------------------------------
`define GDRV_FLAGS_HELD 15'h7770
`define GDRV_FLAGS_SHORT 15'h6660
`define GDRV_FLAGS_RST 15'h0000
`define GDRV_BLOCK_RST 6'h00
`define GDRV_VERSION_DEF 8'h01

// ---------------------------------------------------------------
// Serial frame
// ---------------------------------------------------------------
`define GDRV_FRAME_BITS 6'd40
`define GDRV_FRAME_WR_BIT 39

`endif

/* rtl/gdrv_pkg.sv */
// Types shared by the fault status block and its serial port
package gdrv_pkg;

	// Index 0 is phase U, 1 is V, 2 is W
	typedef struct packed {
		logic [2:0] gnd;
		logic [2:0] sup;
		logic [2:0] cnt;
	} short_evt_s;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [6:0] addr;
		logic [31:0] wdata;
	} spi_req_s;

	typedef struct packed {
		logic [2:0] c1;
		logic [2:0] c2;
		logic [2:0] c3;
		logic [2:0] cf;
		logic [39:0] rx;
		logic [39:0] tx;
		logic [5:0] cnt;
		logic [31:0] hold;
		spi_req_s req;
	} spi_state_s;

	typedef struct packed {
		logic [6:0] p1;
		logic [6:0] p2;
		logic [6:0] p3;
		logic [6:0] pins;
		logic en_prev;
		logic [14:0] flags;
		logic [5:0] block;
		logic fuse_stb;
		logic [15:0] fuse_data;
	} top_state_s;

endpackage

/* rtl/gdrv_spi_port.sv */
// Serial register port: 40-bit frames, read data returned in the next frame
`timescale 1ns/100ps
`include "gdrv_consts.svh"

module gdrv_spi_port (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// Serial pins
	input wire logic sck_in,
	input wire logic csn_in,
	input wire logic sdi_in,
	output logic sdo_out,
	output logic sdo_oe_n_out,
	// Register side
	input wire logic [7:0] status_in,
	input wire logic [31:0] rdata_in,
	output gdrv_pkg::spi_req_s req_out
);

	gdrv_pkg::spi_state_s st_r;
	gdrv_pkg::spi_state_s st_nxt;
	logic sck_rise;
	logic sck_fall;
	logic cs_fall;
	logic cs_rise;

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.c1 = {sdi_in, csn_in, sck_in};
		st_nxt.c2 = st_r.c1;
		st_nxt.c3 = st_r.c2;
		// A level only counts once the two late stages agree
		for (int i = 0; i < 3; i++) begin
			if (st_r.c2[i] == st_r.c3[i]) begin
				st_nxt.cf[i] = st_r.c3[i];
			end
		end
		sck_rise = !st_r.cf[0] && st_nxt.cf[0];
		sck_fall = st_r.cf[0] && !st_nxt.cf[0];
		cs_fall = st_r.cf[1] && !st_nxt.cf[1];
		cs_rise = !st_r.cf[1] && st_nxt.cf[1];
		st_nxt.req.wr = 1'b0;
		st_nxt.req.rd = 1'b0;
		if (st_r.req.rd) begin
			st_nxt.hold = rdata_in;
		end
		if (cs_fall) begin
			st_nxt.cnt = 6'd0;
			st_nxt.tx = {status_in, st_r.hold};
		end else if (!st_nxt.cf[1]) begin
			if (sck_rise) begin
				st_nxt.rx = {st_r.rx[38:0], st_nxt.cf[2]};
				if (st_r.cnt != 6'h3f) begin
					st_nxt.cnt = 6'(st_r.cnt + 6'd1);
				end
			end
			// Mode 3: first falling edge comes before any sample, so keep the MSB
			if (sck_fall && st_r.cnt != 6'd0) begin
				st_nxt.tx = {st_r.tx[38:0], 1'b0};
			end
		end
		// Frames of any other length are dropped whole
		if (cs_rise && st_r.cnt == `GDRV_FRAME_BITS) begin
			st_nxt.req.addr = st_r.rx[38:32];
			st_nxt.req.wdata = st_r.rx[31:0];
			st_nxt.req.wr = st_r.rx[`GDRV_FRAME_WR_BIT];
			st_nxt.req.rd = !st_r.rx[`GDRV_FRAME_WR_BIT];
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			st_r <= '0;
			st_r.c1 <= 3'h3;
			st_r.c2 <= 3'h3;
			st_r.c3 <= 3'h3;
			st_r.cf <= 3'h3;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign sdo_out = st_r.tx[39];
	assign sdo_oe_n_out = st_r.cf[1];
	assign req_out = st_r.req;

endmodule

/* rtl/gate_driver_fault_status_regs.sv */
// Global fault flags, input readback and fuse programming entry of the gate driver
`timescale 1ns/100ps
`include "gdrv_consts.svh"

module gate_driver_fault_status_regs #(
	// Arbitrary value, not tied to any real silicon
	parameter logic [7:0] VERSION_CODE = `GDRV_VERSION_DEF
) (
	// Clock and reset
	input wire logic CLK_IN,
	input wire logic RST_IN,
	// Serial host port
	input wire logic SCK_IN,
	input wire logic CSN_IN,
	input wire logic SDI_IN,
	output logic SDO_OUT,
	output logic SDO_OE_N_OUT,
	// Gate control pins
	input wire logic PHASE_U_LOW_GATE_IN,
	input wire logic PHASE_U_HIGH_GATE_IN,
	input wire logic PHASE_V_LOW_GATE_IN,
	input wire logic PHASE_V_HIGH_GATE_IN,
	input wire logic PHASE_W_LOW_GATE_IN,
	input wire logic PHASE_W_HIGH_GATE_IN,
	input wire logic DRV_EN_IN,
	// Detector events and comparators
	input wire gdrv_pkg::short_evt_s SHORT_EVT_IN,
	input wire logic [3:0] OVERTEMP_CMP_IN,
	// Protection outputs
	output logic FAULT_STATUS_OUT,
	output logic DRIVER_DISABLE_OUT,
	output logic [5:0] GATE_BLOCK_OUT,
	// Fuse programming
	output logic FUSE_PROG_STROBE_OUT,
	output logic [15:0] FUSE_PROG_DATA_OUT
);

	gdrv_pkg::top_state_s st_r;
	gdrv_pkg::top_state_s st_nxt;
	gdrv_pkg::spi_req_s req;
	logic [31:0] rdata;
	logic [14:0] set_vec;
	logic [14:0] clr_vec;
	logic [5:0] blk_set;
	logic drv_rise;

	function automatic logic [31:0] read_mux(input logic [6:0] addr, input logic [14:0] flags,
			input logic [6:0] pins, input logic [3:0] ot, input logic [7:0] ver);
		logic [31:0] d;
		d = 32'h0000_0000;
		if (addr == `GDRV_ADDR_FLAGS) begin
			d = {17'h00000, flags};
		end else if (addr == `GDRV_ADDR_READBACK) begin
			d = {ver, 12'h000, ot, 1'b0, pins};
		end
		return d;
	endfunction

	// ---------------------------------------------------------------
	// Serial port
	// ---------------------------------------------------------------
	gdrv_spi_port u_spi (
		.clk_in(CLK_IN),
		.rst_in(RST_IN),
		.sck_in(SCK_IN),
		.csn_in(CSN_IN),
		.sdi_in(SDI_IN),
		.sdo_out(SDO_OUT),
		.sdo_oe_n_out(SDO_OE_N_OUT),
		.status_in({6'h00, DRIVER_DISABLE_OUT, FAULT_STATUS_OUT}),
		.rdata_in(rdata),
		.req_out(req)
	);

	assign rdata = read_mux(req.addr, st_r.flags, st_r.pins, OVERTEMP_CMP_IN, VERSION_CODE);

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.p1 = {DRV_EN_IN, PHASE_W_HIGH_GATE_IN, PHASE_W_LOW_GATE_IN, PHASE_V_HIGH_GATE_IN,
			PHASE_V_LOW_GATE_IN, PHASE_U_HIGH_GATE_IN, PHASE_U_LOW_GATE_IN};
		st_nxt.p2 = st_r.p1;
		st_nxt.p3 = st_r.p2;
		for (int i = 0; i < 7; i++) begin
			if (st_r.p2[i] == st_r.p3[i]) begin
				st_nxt.pins[i] = st_r.p3[i];
			end
		end
		st_nxt.en_prev = st_r.pins[6];
		drv_rise = st_r.pins[6] && !st_r.en_prev;

		set_vec = 15'h0000;
		set_vec[`GDRV_FLG_CNT_U] = SHORT_EVT_IN.cnt[0];
		set_vec[`GDRV_FLG_GND_U] = SHORT_EVT_IN.gnd[0];
		set_vec[`GDRV_FLG_SUP_U] = SHORT_EVT_IN.sup[0];
		set_vec[`GDRV_FLG_CNT_V] = SHORT_EVT_IN.cnt[1];
		set_vec[`GDRV_FLG_GND_V] = SHORT_EVT_IN.gnd[1];
		set_vec[`GDRV_FLG_SUP_V] = SHORT_EVT_IN.sup[1];
		set_vec[`GDRV_FLG_CNT_W] = SHORT_EVT_IN.cnt[2];
		set_vec[`GDRV_FLG_GND_W] = SHORT_EVT_IN.gnd[2];
		set_vec[`GDRV_FLG_SUP_W] = SHORT_EVT_IN.sup[2];

		clr_vec = 15'h0000;
		if (req.wr && req.addr == `GDRV_ADDR_FLAGS) begin
			clr_vec = req.wdata[14:0];
		end
		if (drv_rise) begin
			clr_vec = 15'h7fff;
		end
		// Set wins over clear so no event is lost; bits not held stay zero
		st_nxt.flags = ((st_r.flags & ~clr_vec) | set_vec) & `GDRV_FLAGS_HELD;

		// Ground short blocks the high side, supply short the low side
		blk_set = {SHORT_EVT_IN.gnd[2], SHORT_EVT_IN.sup[2], SHORT_EVT_IN.gnd[1], SHORT_EVT_IN.sup[1],
			SHORT_EVT_IN.gnd[0], SHORT_EVT_IN.sup[0]};
		// Released only once the host turns that gate input off
		st_nxt.block = (st_r.block & st_r.pins[5:0]) | blk_set;

		st_nxt.fuse_stb = 1'b0;
		if (req.wr && req.addr == `GDRV_ADDR_FUSE) begin
			st_nxt.fuse_stb = 1'b1;
			st_nxt.fuse_data = req.wdata[15:0];
		end
	end

	always_ff @(posedge CLK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			st_r <= '0;
			st_r.flags <= `GDRV_FLAGS_RST;
			st_r.block <= `GDRV_BLOCK_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign FAULT_STATUS_OUT = |st_r.flags;
	assign DRIVER_DISABLE_OUT = |(st_r.flags & `GDRV_FLAGS_SHORT);
	assign GATE_BLOCK_OUT = st_r.block;
	assign FUSE_PROG_STROBE_OUT = st_r.fuse_stb;
	assign FUSE_PROG_DATA_OUT = st_r.fuse_data;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge CLK_IN);
	endclocking
	default disable iff (RST_IN);

	gnd_u_latch_a: assert property (SHORT_EVT_IN.gnd[0] |=> st_r.flags[5] && DRIVER_DISABLE_OUT)
		else $error("phase U ground short not latched");
	sup_u_latch_a: assert property (SHORT_EVT_IN.sup[0] |=> st_r.flags[6] && GATE_BLOCK_OUT[0])
		else $error("phase U supply short not latched");
	cnt_v_latch_a: assert property (SHORT_EVT_IN.cnt[1] ##1 !drv_rise && !clr_vec[8] |=> st_r.flags[8])
		else $error("phase V counter flag lost");
	gnd_v_latch_a: assert property (SHORT_EVT_IN.gnd[1] |=> st_r.flags[9] && DRIVER_DISABLE_OUT)
		else $error("phase V ground short not latched");
	sup_w_latch_a: assert property (SHORT_EVT_IN.sup[2] |=> st_r.flags[14] && GATE_BLOCK_OUT[4])
		else $error("phase W supply short not latched");
	fault_or_a: assert property (FAULT_STATUS_OUT == (st_r.flags != 15'h0000))
		else $error("fault output differs from flag OR");
	unused_zero_a: assert property (!st_r.flags[7] && !st_r.flags[11] && !rdata[7])
		else $error("unused bit reads one");
	flag_clear_a: assert property (req.wr && req.addr == `GDRV_ADDR_FLAGS && req.wdata[5]
			&& !SHORT_EVT_IN.gnd[0] |=> !st_r.flags[5])
		else $error("write one did not clear flag");
	en_clear_a: assert property (drv_rise && SHORT_EVT_IN == '0 |=> st_r.flags == 15'h0000)
		else $error("driver enable cycle left flags set");
	fuse_pulse_a: assert property (req.wr && req.addr == `GDRV_ADDR_FUSE |=> FUSE_PROG_STROBE_OUT
			##1 !FUSE_PROG_STROBE_OUT)
		else $error("fuse strobe not a single pulse");
	block_hold_a: assert property (GATE_BLOCK_OUT[1] && st_r.pins[1] |=> GATE_BLOCK_OUT[1])
		else $error("transistor released while gate still on");

	// ---------------------------------------------------------------
	// Checks: remaining flag latches
	// ---------------------------------------------------------------
	// Each event shows in its flag and in the outputs it feeds one cycle later
	cnt_u_latch_a: assert property (SHORT_EVT_IN.cnt[0] |=> st_r.flags[4] && FAULT_STATUS_OUT)
		else $error("phase U counter flag not latched");
	sup_u_disable_a: assert property (SHORT_EVT_IN.sup[0] |=> DRIVER_DISABLE_OUT)
		else $error("phase U supply short left driver enabled");
	gnd_v_block_a: assert property (SHORT_EVT_IN.gnd[1] |=> GATE_BLOCK_OUT[3])
		else $error("phase V high side not blocked");
	sup_v_latch_a: assert property (SHORT_EVT_IN.sup[1]
			|=> st_r.flags[10] && DRIVER_DISABLE_OUT && GATE_BLOCK_OUT[2])
		else $error("phase V supply short not latched");
	cnt_w_latch_a: assert property (SHORT_EVT_IN.cnt[2] |=> st_r.flags[12] && FAULT_STATUS_OUT)
		else $error("phase W counter flag not latched");
	gnd_w_latch_a: assert property (SHORT_EVT_IN.gnd[2]
			|=> st_r.flags[13] && DRIVER_DISABLE_OUT && GATE_BLOCK_OUT[5])
		else $error("phase W ground short not latched");

	// ---------------------------------------------------------------
	// Checks: holding and clearing
	// ---------------------------------------------------------------
	// Only a write-one or a driver enable cycle may lift the disable
	disable_hold_a: assert property (DRIVER_DISABLE_OUT && !(req.wr && req.addr == `GDRV_ADDR_FLAGS)
			&& !drv_rise |=> DRIVER_DISABLE_OUT)
		else $error("driver disable dropped without a clear");
	flag_keep_a: assert property (st_r.flags[5] && req.wr && req.addr == `GDRV_ADDR_FLAGS
			&& !req.wdata[5] && !drv_rise |=> st_r.flags[5])
		else $error("write zero cleared a flag");
	block_release_a: assert property (GATE_BLOCK_OUT[0] && !st_r.pins[0] && !SHORT_EVT_IN.sup[0] |=> !GATE_BLOCK_OUT[0])
		else $error("blocked transistor not released");

	// ---------------------------------------------------------------
	// Checks: register reads and fuse strobe
	// ---------------------------------------------------------------
	readback_pins_a: assert property (req.addr == `GDRV_ADDR_READBACK |-> rdata[7:0] == {1'b0, st_r.pins})
		else $error("readback pin field wrong");
	version_field_a: assert property (req.addr == `GDRV_ADDR_READBACK |-> rdata[31:24] == VERSION_CODE)
		else $error("readback version field wrong");
	temp_field_a: assert property (req.addr == `GDRV_ADDR_READBACK |-> rdata[23:8] == {12'h000, OVERTEMP_CMP_IN})
		else $error("readback comparator field wrong");
	fuse_data_a: assert property (req.wr && req.addr == `GDRV_ADDR_FUSE
			|=> FUSE_PROG_DATA_OUT == 16'($past(req.wdata)))
		else $error("fuse data not taken from write");
	fuse_quiet_a: assert property (!(req.wr && req.addr == `GDRV_ADDR_FUSE) |=> !FUSE_PROG_STROBE_OUT)
		else $error("fuse strobe without a write");

endmodule

/* testbench/gdrv_host_model.sv */
// Serial host model issuing 40-bit mode-3 frames
`timescale 1ns/100ps

module gdrv_host_model (
	// Clock
	input wire logic clk_in,
	// Serial pins
	input wire logic sdo_in,
	input wire logic sdo_oe_n_in,
	output logic sck_out,
	output logic csn_out,
	output logic sdi_out
);
	// ----------------------------------------
	// Frame engine
	// ----------------------------------------
	initial begin
		sck_out = 1'b1;
		csn_out = 1'b1;
		sdi_out = 1'b0;
	end

	// Levels held 5 clocks, above the 4-clock filter delay; undriven SDO reads as unknown
	task automatic xfer(input logic [39:0] tx, output logic [39:0] rx);
		csn_out <= 1'b0;
		repeat (8) @(posedge clk_in);
		for (int i = 39; i >= 0; i--) begin
			sck_out <= 1'b0;
			sdi_out <= tx[i];
			repeat (5) @(posedge clk_in);
			sck_out <= 1'b1;
			rx[i] = sdo_oe_n_in ? 1'bx : sdo_in;
			repeat (5) @(posedge clk_in);
		end
		csn_out <= 1'b1;
		sdi_out <= ~tx[0];
		repeat (12) @(posedge clk_in);
	endtask
endmodule

/* testbench/gate_driver_fault_status_regs_tb.sv */
// Self-checking bench of the fault status block
`timescale 1ns/100ps
`include "gdrv_consts.svh"

module gate_driver_fault_status_regs_tb;
	logic clk, rst, sck, csn, sdi, sdo, sdo_oe_n, fault, dis, stb;
	logic [6:0] pins;
	logic [3:0] ot;
	logic [5:0] blk;
	logic [15:0] fdata;
	gdrv_pkg::short_evt_s evt;
	int errors, checked, strobes, cycles;

	gate_driver_fault_status_regs #(.VERSION_CODE(8'h5a)) i_gate_driver_fault_status_regs (
		.CLK_IN(clk), .RST_IN(rst), .SCK_IN(sck), .CSN_IN(csn), .SDI_IN(sdi), .SDO_OUT(sdo),
		.SDO_OE_N_OUT(sdo_oe_n), .PHASE_U_LOW_GATE_IN(pins[0]), .PHASE_U_HIGH_GATE_IN(pins[1]),
		.PHASE_V_LOW_GATE_IN(pins[2]), .PHASE_V_HIGH_GATE_IN(pins[3]), .PHASE_W_LOW_GATE_IN(pins[4]),
		.PHASE_W_HIGH_GATE_IN(pins[5]), .DRV_EN_IN(pins[6]), .SHORT_EVT_IN(evt), .OVERTEMP_CMP_IN(ot),
		.FAULT_STATUS_OUT(fault), .DRIVER_DISABLE_OUT(dis), .GATE_BLOCK_OUT(blk),
		.FUSE_PROG_STROBE_OUT(stb), .FUSE_PROG_DATA_OUT(fdata));

	gdrv_host_model i_gdrv_host_model (.clk_in(clk), .sdo_in(sdo), .sdo_oe_n_in(sdo_oe_n),
		.sck_out(sck), .csn_out(csn), .sdi_out(sdi));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	always @(posedge clk) begin
		cycles++;
		if (stb === 1'b1) strobes++;
		// About 30k cycles expected
		if (cycles == 80000) begin
			errors++;
			report_and_stop();
		end
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [6:0] a, input logic [31:0] d);
		logic [39:0] r;
		i_gdrv_host_model.xfer({1'b1, a, d}, r);
	endtask

	// Read data comes back in the following frame
	task automatic rd(input logic [6:0] a, output logic [31:0] d);
		logic [39:0] r;
		i_gdrv_host_model.xfer({1'b0, a, 32'h0}, r);
		i_gdrv_host_model.xfer({1'b0, a, 32'h0}, r);
		d = r[31:0];
	endtask

	task automatic pulse(input logic [8:0] e);
		@(posedge clk);
		evt <= e;
		@(posedge clk);
		evt <= 9'h000;
		repeat (2) @(posedge clk);
	endtask

	task automatic report_and_stop();
		$display("Checks %0d, errors %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_shorts();
		logic [31:0] d;
		int b;
		for (int k = 0; k < 9; k++) begin
			b = 4 + 4 * (k % 3) + ((k / 3 == 2) ? 0 : k / 3 + 1);
			pulse(9'h001 << (6 - 3 * (k / 3) + k % 3));
			chk(fault, 1);
			chk(dis, k < 6);
			rd(`GDRV_ADDR_FLAGS, d);
			chk(d, 32'h1 << b);
			wr(`GDRV_ADDR_FLAGS, ~(32'h1 << b) & 32'h7fff);
			chk(fault, 1);
			wr(`GDRV_ADDR_FLAGS, 32'h1 << b);
			rd(`GDRV_ADDR_FLAGS, d);
			chk({d[15:0], fault, dis}, 18'h0);
		end
		pulse(9'h1ff);
		rd(`GDRV_ADDR_FLAGS, d);
		chk(d, 32'h7770);
		wr(`GDRV_ADDR_FLAGS, 32'hffffffff);
		rd(`GDRV_ADDR_FLAGS, d);
		chk(d, 32'h0);
		$display("t_shorts done");
	endtask

	task automatic t_gate();
		pins[1] <= 1'b1;
		repeat (6) @(posedge clk);
		pulse(9'h040);
		chk(blk, 6'h02);
		wr(`GDRV_ADDR_FLAGS, 32'h1 << `GDRV_FLG_GND_U);
		chk({dis, blk}, 7'h02);
		pins[1] <= 1'b0;
		repeat (8) @(posedge clk);
		chk(blk, 6'h00);
		$display("t_gate done");
	endtask

	task automatic t_readback();
		logic [31:0] d;
		for (int k = 0; k < 2; k++) begin
			pins <= k ? 7'h2a : 7'h55;
			ot <= k ? 4'h5 : 4'ha;
			repeat (8) @(posedge clk);
			rd(`GDRV_ADDR_READBACK, d);
			chk(d, {8'h5a, 12'h0, k ? 4'h5 : 4'ha, 1'b0, k ? 7'h2a : 7'h55});
		end
		pins <= 7'h40;
		rd(7'h7f, d);
		chk(d, 32'h0);
		rd(`GDRV_ADDR_FUSE, d);
		chk(d, 32'h0);
		$display("t_readback done");
	endtask

	task automatic t_fuse_drv_en();
		logic [31:0] d;
		logic [39:0] r;
		int s0;
		s0 = strobes;
		wr(`GDRV_ADDR_FUSE, 32'h0000bd01);
		chk(strobes - s0, 1);
		chk(fdata, 16'hbd01);
		pulse(9'h1ff);
		i_gdrv_host_model.xfer({1'b0, 7'h7f, 32'h0}, r);
		chk(r[39:32], 8'h03);
		pins[6] <= 1'b0;
		repeat (8) @(posedge clk);
		pins[6] <= 1'b1;
		repeat (8) @(posedge clk);
		rd(`GDRV_ADDR_FLAGS, d);
		chk({d[15:0], fault}, 17'h0);
		$display("t_fuse_drv_en done");
	endtask

	initial begin
		rst = 1'b1;
		pins = 7'h40;
		ot = 4'h0;
		evt = 9'h000;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (10) @(posedge clk);
		chk({fault, dis, sdo_oe_n, blk, stb}, 10'h080);
		t_shorts();
		t_gate();
		t_readback();
		t_fuse_drv_en();
		report_and_stop();
	end
endmodule
